// ==== shared/pdc_pkg.sv ====
// Package for the port and decode-control block: command codes,
// flag positions, widths and reset values.
// Assumes a single 50 MHz clock domain for all users.
package pdc_pkg;

   // Command codes on the serial command link
   localparam logic [7:0] CMD_DECODE_CTRL = 8'hD8;
   localparam logic [7:0] CMD_PORT_DIR    = 8'hDB;
   localparam logic [7:0] CMD_PORT_OUT    = 8'hDC;
   localparam logic [7:0] CMD_PORT_READ   = 8'hDD;

   // Widths
   localparam int unsigned PORT_W  = 5;
   localparam int unsigned BYTE_W  = 8;
   localparam int unsigned READ_W  = 7;
   localparam int unsigned CNT_W   = 3;
   localparam int unsigned SYNC_W  = 9;

   // Bit position of the last bit of a byte
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Decode-control flag positions
   localparam int unsigned F_GAIN_EXT   = 0;
   localparam int unsigned F_FILT_SRC   = 1;
   localparam int unsigned F_RATE_1FS   = 2;
   localparam int unsigned F_RSVD_A     = 3;
   localparam int unsigned F_DOUT_SRC   = 4;
   localparam int unsigned F_RSVD_B     = 5;
   localparam int unsigned F_SHORT_WORD = 6;
   localparam int unsigned F_EQ_OE      = 7;

   // Positions inside the synchroniser vector
   localparam int unsigned S_STROBE = 0;
   localparam int unsigned S_SCLK   = 1;
   localparam int unsigned S_DIN    = 2;
   localparam int unsigned S_LOCK   = 3;
   localparam int unsigned S_PIN0   = 4;

   // Reset values
   localparam logic [7:0] DECODE_CTRL_RST = 8'h00;
   localparam logic [4:0] PORT_DIR_RST    = 5'h00;
   localparam logic [4:0] PORT_LVL_RST    = 5'h00;

endpackage : pdc_pkg

// ==== hdl/pdc_sync.sv ====
// Two-flop synchroniser with edge detection for a vector of pins.
// Assumes the inputs are asynchronous to clk; the first stage feeds
// nothing but the second.
`timescale 1ns/1ps
module pdc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
   } pdc_sync_s;

   pdc_sync_s s_q;
   pdc_sync_s s_d;

   // Shift chain; prev only ever looks at the second stage
   always_comb begin
      s_d      = s_q;
      s_d.meta = async_in;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Edges seen on the settled stage
   assign level = s_q.sync;
   assign rise  = s_q.sync & ~s_q.prev;
   assign fall  = ~s_q.sync & s_q.prev;

endmodule : pdc_sync

// ==== hdl/pdc_port_ctrl.sv ====
// Port and decode-control block: serial command receiver, decode-path
// flags, five general-purpose port pins and the port readback shifter.
// Assumes the controller drives strobe, shift clock and data from its
// own clock; all link pins are sampled by clk (50 MHz).
//
// Contract
// - Flag bit 0 picks external gain scaling
// - Flag bit 1 picks external serial source
// - Flag bit 2 picks 1 fs audio output
// - Flag bit 4 picks 20-bit digital output
// - Flag bit 6 picks 16-bit serial input
// - Flag bit 7 enables equaliser flag pin
// - Five port pins, inputs after reset
// - Read shifts pins, detect, gain out
// - Lock high accepts only port, control commands
// - Unlocked command aborts running track operation
// - Direction command: one means output
// - Output command sets driven pin levels
// - Control written by code then flag byte
`timescale 1ns/1ps
module pdc_port_ctrl (
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Serial command link
   input  wire logic       command_strobe,
   input  wire logic       serial_shift_clock,
   input  wire logic       serial_cmd_data_in,
   input  wire logic       port_command_lock,
   output logic            serial_status_out,
   // General-purpose port pins, bit 0 is port_pin_zero, bit 4 port_pin_four
   input  wire logic [4:0] port_pin_in,
   output logic      [4:0] port_pin_out,
   output logic      [4:0] port_pin_oe_n,
   // Decoder status for readback
   input  wire logic       decode_detect,
   input  wire logic       gain_status,
   // Track operation status and other-command hand-off
   input  wire logic       track_op_active,
   output logic            track_op_abort,
   output logic            other_cmd_valid,
   output logic      [7:0] other_cmd_code,
   // Equaliser flag pin
   input  wire logic       eq_monitor_data,
   output logic            eq_flag_pin_out,
   output logic            eq_flag_pin_oe_n,
   // Decode-path flags
   output logic            external_gain_scale_sel,
   output logic            filter_source_sel,
   output logic            audio_port_rate_sel,
   output logic            digital_out_source_sel,
   output logic            serial_in_short_word_sel
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   logic [pdc_pkg::SYNC_W-1:0] pin_lvl;
   logic [pdc_pkg::SYNC_W-1:0] pin_rise;
   logic [pdc_pkg::SYNC_W-1:0] pin_fall;

   pdc_sync #(
      .WIDTH (pdc_pkg::SYNC_W)
   ) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({port_pin_in, port_command_lock, serial_cmd_data_in,
                  serial_shift_clock, command_strobe}),
      .level    (pin_lvl),
      .rise     (pin_rise),
      .fall     (pin_fall)
   );

   logic       strobe_rise;
   logic       strobe_fall;
   logic       strobe_lvl;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       din_lvl;
   logic       lock_lvl;
   logic [4:0] pins_sync;

   assign strobe_rise = pin_rise[pdc_pkg::S_STROBE];
   assign strobe_fall = pin_fall[pdc_pkg::S_STROBE];
   assign strobe_lvl  = pin_lvl[pdc_pkg::S_STROBE];
   assign sclk_rise   = pin_rise[pdc_pkg::S_SCLK];
   assign sclk_fall   = pin_fall[pdc_pkg::S_SCLK];
   assign din_lvl     = pin_lvl[pdc_pkg::S_DIN];
   assign lock_lvl    = pin_lvl[pdc_pkg::S_LOCK];
   assign pins_sync   = pin_lvl[pdc_pkg::S_PIN0 +: pdc_pkg::PORT_W];

   ////////////////////////////////////////////////////////////////////
   // Command decode helpers

   // Commands that stay usable while the lock pin is high
   function automatic logic is_lockable(input logic [7:0] code);
      is_lockable = (code == pdc_pkg::CMD_DECODE_CTRL) || (code == pdc_pkg::CMD_PORT_DIR) ||
                    (code == pdc_pkg::CMD_PORT_OUT) || (code == pdc_pkg::CMD_PORT_READ);
   endfunction : is_lockable

   // Commands that carry a data byte after the code
   function automatic logic is_two_byte(input logic [7:0] code);
      is_two_byte = (code == pdc_pkg::CMD_DECODE_CTRL) || (code == pdc_pkg::CMD_PORT_DIR) ||
                    (code == pdc_pkg::CMD_PORT_OUT);
   endfunction : is_two_byte

   ////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0] shift;       // incoming byte, LSB first
      logic [2:0] bit_cnt;
      logic       have_code;
      logic       have_data;
      logic [7:0] code;
      logic [7:0] ctrl;        // decode_path_control
      logic [4:0] dir;         // port_direction, 1 = output
      logic [4:0] lvl;         // port_output_level
      logic [6:0] rd_shift;    // port_readback shifter
      logic       other_vld;
      logic [7:0] other_code;
      logic       abort;
   } pdc_state_s;

   pdc_state_s st_q;
   pdc_state_s st_d;

   logic [7:0] byte_in;
   assign byte_in = {din_lvl, st_q.shift[7:1]};

   ////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      st_d           = st_q;
      st_d.other_vld = 1'b0;
      st_d.abort     = 1'b0;

      // A new frame starts clean so a torn frame cannot leak bits
      if (strobe_rise) begin
         st_d.bit_cnt   = '0;
         st_d.have_code = 1'b0;
         st_d.have_data = 1'b0;
      end else if (strobe_lvl && sclk_rise) begin
         st_d.shift   = byte_in;
         st_d.bit_cnt = st_q.bit_cnt + 3'h1;
         if (st_q.bit_cnt == pdc_pkg::LAST_BIT) begin
            if (!st_q.have_code) begin
               st_d.code      = byte_in;
               st_d.have_code = 1'b1;
            end else if (!st_q.have_data && is_two_byte(st_q.code)) begin
               st_d.have_data = 1'b1;
               unique case (st_q.code)
                  pdc_pkg::CMD_DECODE_CTRL: st_d.ctrl = byte_in;
                  pdc_pkg::CMD_PORT_DIR:    st_d.dir = byte_in[pdc_pkg::PORT_W-1:0];
                  pdc_pkg::CMD_PORT_OUT:    st_d.lvl = byte_in[pdc_pkg::PORT_W-1:0];
                  default:                  st_d.have_data = 1'b1;
               endcase
            end
         end
      end

      // Frame end: one-byte commands act here
      if (strobe_fall && st_q.have_code) begin
         if (st_q.code == pdc_pkg::CMD_PORT_READ) begin
            st_d.rd_shift = {gain_status, decode_detect, pins_sync};
         end else if (!is_lockable(st_q.code)) begin
            if (!lock_lvl) begin
               st_d.other_vld  = 1'b1;
               st_d.other_code = st_q.code;
               st_d.abort      = track_op_active;
            end
         end
      end else if (!strobe_lvl && sclk_fall) begin
         st_d.rd_shift = {1'b0, st_q.rd_shift[6:1]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= '0;
         st_q.dir  <= pdc_pkg::PORT_DIR_RST;
         st_q.lvl  <= pdc_pkg::PORT_LVL_RST;
         st_q.ctrl <= pdc_pkg::DECODE_CTRL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign serial_status_out = st_q.rd_shift[0];
   assign other_cmd_valid   = st_q.other_vld;
   assign other_cmd_code    = st_q.other_code;
   assign track_op_abort    = st_q.abort;

   assign port_pin_out  = st_q.lvl;
   assign port_pin_oe_n = ~st_q.dir;

   assign external_gain_scale_sel  = st_q.ctrl[pdc_pkg::F_GAIN_EXT];
   assign filter_source_sel        = st_q.ctrl[pdc_pkg::F_FILT_SRC];
   assign audio_port_rate_sel      = st_q.ctrl[pdc_pkg::F_RATE_1FS];
   assign digital_out_source_sel   = st_q.ctrl[pdc_pkg::F_DOUT_SRC];
   assign serial_in_short_word_sel = st_q.ctrl[pdc_pkg::F_SHORT_WORD];

   // Flag pin drive; monitor data goes straight through
   assign eq_flag_pin_out  = eq_monitor_data;
   assign eq_flag_pin_oe_n = ~st_q.ctrl[pdc_pkg::F_EQ_OE];

endmodule : pdc_port_ctrl

// ==== verification/pdc_port_ctrl_monitor.sv ====
// Checker for the port and decode-control block.
// Sees only the top-level ports; bound from the bench top file.
`timescale 1ns/1ps
module pdc_port_ctrl_monitor (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       command_strobe,
   input wire logic       port_command_lock,
   input wire logic       serial_status_out,
   input wire logic [4:0] port_pin_out,
   input wire logic [4:0] port_pin_oe_n,
   input wire logic       track_op_abort,
   input wire logic       other_cmd_valid,
   input wire logic       eq_monitor_data,
   input wire logic       eq_flag_pin_out,
   input wire logic       eq_flag_pin_oe_n,
   input wire logic       external_gain_scale_sel,
   input wire logic       filter_source_sel,
   input wire logic       audio_port_rate_sel,
   input wire logic       digital_out_source_sel,
   input wire logic       serial_in_short_word_sel
);
   logic [2:0] lo_q;
   logic [2:0] hi_q;
   logic [5:0] flags;
   assign flags = {eq_flag_pin_oe_n, serial_in_short_word_sel, digital_out_source_sel,
                   audio_port_rate_sel, filter_source_sel, external_gain_scale_sel};
   // Cycles the strobe pin has sat still; saturates so it never wraps
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_q <= 3'h0;
         hi_q <= 3'h0;
      end else begin
         lo_q <= command_strobe ? 3'h0 : lo_q + {2'h0, lo_q != 3'h7};
         hi_q <= command_strobe ? hi_q + {2'h0, hi_q != 3'h7} : 3'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_flag_pin_copy: assert property (eq_flag_pin_out == eq_monitor_data)
      else $error("flag pin does not follow monitor data");
   a_reset_values: assert property ($rose(rst_n) |-> port_pin_oe_n == 5'h1f && flags == 6'h20)
      else $error("outputs not at reset values");
   a_flags_hold: assert property (lo_q == 3'h7 |-> $stable(flags))
      else $error("flags moved outside a frame");
   a_pins_hold: assert property (lo_q == 3'h7 |-> $stable(port_pin_out) && $stable(port_pin_oe_n))
      else $error("port pins moved outside a frame");
   a_abort_with_cmd: assert property (track_op_abort |-> other_cmd_valid)
      else $error("abort without an accepted command");
   a_pulse_once: assert property (other_cmd_valid |=> !other_cmd_valid)
      else $error("command pulse longer than one cycle");
   a_lock_refuses: assert property (other_cmd_valid |-> !$past(port_command_lock, 3) && !$past(command_strobe))
      else $error("command accepted under lock or mid frame");
   a_read_quiet: assert property (hi_q == 3'h7 |-> $stable(serial_status_out))
      else $error("readback shifted inside a frame");
endmodule : pdc_port_ctrl_monitor

// ==== verification/pdc_host_model.sv ====
// Controller model for the serial command link.
// Assumes the bench clock; all pins change just after its edges.
`timescale 1ns/1ps
module pdc_host_model (
   input  wire logic clk,
   output logic      strobe,
   output logic      sclk,
   output logic      din,
   output logic      lock
);
   initial begin
      strobe = 1'b0;
      sclk = 1'b0;
      din = 1'b0;
      lock = 1'b0;
   end
   // Half link period of 80 ns is four bench clocks
   task automatic half(input int n);
      repeat (4 * n) @(posedge clk);
   endtask : half
   // One shift-clock pulse, 80 ns high then 80 ns low for a 160 ns period;
   // the clock stands low outside it
   task automatic pulse();
      sclk <= 1'b1;
      half(1);
      sclk <= 1'b0;
      half(1);
   endtask : pulse
   // Lock set while strobe low, bits LSB first
   task automatic frame(input logic [15:0] bits, input int n, input logic lk);
      lock <= lk;
      half(1);
      strobe <= 1'b1;
      for (int i = 0; i < n; i++) begin
         din <= bits[i];
         half(1);
         pulse();
      end
      strobe <= 1'b0;
      din <= ~din; // Released line never shows a stale bit
      half(2);
   endtask : frame
endmodule : pdc_host_model

// ==== verification/port_and_decode_control_test.sv ====
// Self-checking bench for the port and decode-control block.
// Assumes the host model drives the link; notes queue up here.
`timescale 1ns/1ps
module port_and_decode_control_test;
   logic        clk = 1'b0, rst_n = 1'b0, probe = 1'b0, vs = 1'b0, as_ = 1'b0;
   logic        det = 1'b0, gain = 1'b0, trk = 1'b0, eqm = 1'b0;
   logic        strobe, sclk, din, lock, sso, abort, valid, eqo, eqoe_n;
   logic [4:0]  pins = 5'h00, dir = 5'h00, lvl = 5'h00, pout, poe_n;
   wire  [4:0]  fl;
   logic [7:0]  ctrl = 8'h00, e_code = 8'h00, code;
   logic [26:0] q[$];
   int          fails = 0, tests_run = 0;
   always #10 clk = ~clk;
   always @(posedge clk) eqm <= 1'($urandom());
   pdc_host_model host (.clk(clk), .strobe(strobe), .sclk(sclk), .din(din), .lock(lock));
   pdc_port_ctrl dut (.clk(clk), .rst_n(rst_n), .command_strobe(strobe), .serial_shift_clock(sclk),
      .serial_cmd_data_in(din), .port_command_lock(lock), .serial_status_out(sso),
      .port_pin_in(pins), .port_pin_out(pout), .port_pin_oe_n(poe_n), .decode_detect(det),
      .gain_status(gain), .track_op_active(trk), .track_op_abort(abort), .other_cmd_valid(valid),
      .other_cmd_code(code), .eq_monitor_data(eqm), .eq_flag_pin_out(eqo), .eq_flag_pin_oe_n(eqoe_n),
      .external_gain_scale_sel(fl[0]), .filter_source_sel(fl[1]), .audio_port_rate_sel(fl[2]),
      .digital_out_source_sel(fl[3]), .serial_in_short_word_sel(fl[4]));
   ////////////////////////////////////////////////////////////////////////////
   // Expected snapshot from the bench's own copies
   function automatic logic [26:0] snap(input logic s, input logic v, input logic a);
      return {a, v, e_code, ~ctrl[7], ctrl[6], ctrl[4], ctrl[2:0], dir, lvl & dir, s};
   endfunction : snap
   task automatic check(input logic [26:0] seen, input logic [26:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic note(input logic [26:0] e);
      q.push_back(e);
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
   endtask : note
   // Watcher: each settled snapshot against the oldest note
   always @(posedge clk) begin
      if (probe) begin
         check({as_, vs, code, eqoe_n, fl, ~poe_n, pout & ~poe_n, sso}, q.pop_front());
         vs = 1'b0;
         as_ = 1'b0;
      end
      if (valid)
         vs = 1'b1;
      if (abort)
         as_ = 1'b1;
   end
   // Write frame; a short frame must change nothing
   task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic lk, input int n);
      host.frame({d, c}, n, lk);
      if (n == 16)
         case (c)
            pdc_pkg::CMD_DECODE_CTRL: ctrl = d;
            pdc_pkg::CMD_PORT_DIR: dir = d[4:0];
            pdc_pkg::CMD_PORT_OUT: lvl = d[4:0];
            default: ;
         endcase
      note(snap(1'b0, 1'b0, 1'b0));
   endtask : wr
   task automatic oth(input logic [7:0] c, input logic lk);
      host.frame({8'h00, c}, 8, lk);
      if (!lk)
         e_code = c;
      note(snap(1'b0, !lk, !lk && trk));
   endtask : oth
   // Readback order pin0..pin4, detect, gain, then zero
   task automatic rd(input logic lk);
      logic [7:0] rb;
      rb = {1'b0, gain, det, pins};
      host.frame({8'h00, pdc_pkg::CMD_PORT_READ}, 8, lk);
      for (int i = 0; i < 8; i++) begin
         note(snap(rb[i], 1'b0, 1'b0));
         if (i < 7)
            host.pulse();
      end
   endtask : rd
   task automatic tally_and_finish();
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      void'($urandom(32'h0000_06f6));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      note(snap(1'b0, 1'b0, 1'b0));
      wr(pdc_pkg::CMD_DECODE_CTRL, 8'h57, 1'b0, 16);
      wr(pdc_pkg::CMD_DECODE_CTRL, 8'h80, 1'b1, 16);
      wr(pdc_pkg::CMD_PORT_DIR, 8'h1f, 1'b0, 8);
      for (int k = 0; k < 6; k++) begin
         d = 8'($urandom());
         // Reserved bits zero, no source and pin clash
         d = d & 8'hd7;
         if (d[1])
            d[7] = 1'b0;
         wr(pdc_pkg::CMD_DECODE_CTRL, d, k[0], 16);
         wr(pdc_pkg::CMD_PORT_DIR, 8'($urandom()), k[1], 16);
         wr(pdc_pkg::CMD_PORT_OUT, 8'($urandom()), 1'b0, 16);
         {gain, det, pins} <= 7'($urandom());
         @(posedge clk);
         rd(k[2]);
      end
      trk <= 1'b1;
      oth(8'h06, 1'b1);
      oth(8'h06, 1'b0);
      trk <= 1'b0;
      oth(8'h10, 1'b0);
      repeat (4) @(posedge clk);
      tally_and_finish();
   end
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
endmodule : port_and_decode_control_test
bind pdc_port_ctrl pdc_port_ctrl_monitor mon (.clk(clk), .rst_n(rst_n), .command_strobe(command_strobe),
   .port_command_lock(port_command_lock), .serial_status_out(serial_status_out), .port_pin_out(port_pin_out),
   .port_pin_oe_n(port_pin_oe_n), .track_op_abort(track_op_abort), .other_cmd_valid(other_cmd_valid),
   .eq_monitor_data(eq_monitor_data), .eq_flag_pin_out(eq_flag_pin_out), .eq_flag_pin_oe_n(eq_flag_pin_oe_n),
   .external_gain_scale_sel(external_gain_scale_sel), .filter_source_sel(filter_source_sel),
   .audio_port_rate_sel(audio_port_rate_sel), .digital_out_source_sel(digital_out_source_sel),
   .serial_in_short_word_sel(serial_in_short_word_sel));
